// [rtl/jbt_regs.svh]
`ifndef JBT_REGS_SVH
`define JBT_REGS_SVH
// ----------------------------------------------------------------
// Register widths
// ----------------------------------------------------------------
`define JBT_INS_W      16
`define JBT_BSCAN_W    87
`define JBT_ID_W       32
`define JBT_FLASH_W    20
// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define JBT_I_EXTEST   16'h0000
`define JBT_I_SAMPLE   16'h0002
`define JBT_I_IDCODE   16'h0004
`define JBT_I_BYPASS   16'hffff
`define JBT_I_FCON     16'h0082
`define JBT_I_FDAT     16'h0083
`define JBT_I_FADR     16'h0084
`define JBT_I_FSCL     16'h0085
`define JBT_INS_CAPT   16'h0001
`define JBT_INS_RESET  16'h0004
// ----------------------------------------------------------------
// Boundary chain bit positions
// ----------------------------------------------------------------
`define JBT_B_RST_OE   0
`define JBT_B_RST_VAL  1
`define JBT_B_XTAL     2
`define JBT_B_WPU      3
`define JBT_B_ADDR_LO  4
`define JBT_B_DATA_LO  12
`define JBT_B_STB_WR   20
`define JBT_B_STB_RD   21
`define JBT_B_STB_RMW  22
`define JBT_B_PORT_LO  23
// ----------------------------------------------------------------
// Identification and flash command fields
// ----------------------------------------------------------------
`define JBT_ID_VER_LO  28
`define JBT_ID_PART_LO 12
`define JBT_ID_MAKER_LO 1
`define JBT_F_OP_HI    19
`define JBT_F_OP_LO    18
`endif

// [rtl/jbt_pkg.sv]
package jbt_pkg;
  // Tap controller states
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UPD_DR,
    S_SEL_INS, S_CAP_INS, S_SH_INS, S_EX1_INS, S_PA_INS, S_EX2_INS, S_UPD_INS
  } jbt_tap_t;
  // Data register selected by the instruction
  typedef enum logic [1:0] {SEL_BSCAN, SEL_ID, SEL_BYP, SEL_FLASH} jbt_sel_t;
  // Register bus group: address, data, three strobes
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       wr;
    logic       rd;
    logic       rmw;
  } jbt_regbus_t;
  // Byte-wide port pins, four ports flattened
  typedef struct packed {
    logic [31:0] oe;
    logic [31:0] dat;
  } jbt_port_t;
  // Flash indirect command handed to the flash engine
  typedef struct packed {
    logic [1:0]  target;
    logic        wr;
    logic [17:0] wdata;
  } jbt_fcmd_t;
  // State clocked by the test clock
  typedef struct packed {
    jbt_tap_t    state;
    logic [15:0] ins_sh;
    logic [15:0] ins;
    jbt_sel_t    sel;
    logic        ext;
    logic [86:0] dr_sh;
    logic [86:0] cap_s1;
    logic [86:0] cap_s2;
    logic [86:0] upd;
    logic        fl_tgl;
    jbt_fcmd_t   fl_cmd;
    logic [18:0] stat_s1;
    logic [18:0] stat_s2;
  } jbt_tck_st_t;
  // State clocked by the reference clock
  typedef struct packed {
    logic        ext_s1;
    logic        ext_s2;
    logic [86:0] upd_s1;
    logic [86:0] upd_s2;
    logic        tgl_s1;
    logic        tgl_s2;
    logic        tgl_s3;
    logic [32:0] pin_s1;
    logic [32:0] pin_s2;
    jbt_port_t   drv;
    logic        rst_oe;
    logic        rst_out;
    logic        wpu;
    jbt_regbus_t bus;
    logic [32:0] core_in;
    logic        fl_req;
    jbt_fcmd_t   fl_cmd;
  } jbt_ref_st_t;
endpackage

// [rtl/jbt_tap.sv]
`timescale 1ns/1ps
`include "jbt_regs.svh"
// What this block does
// - Four pins, standard tap state sequence
// - Sixteen-bit instruction register, eight instructions
// - Code 0000 selects boundary for external test
// - Code 0002 selects boundary for sample/preload
// - Code 0004 selects 32-bit identification register
// - Code ffff selects one-bit bypass stage
// - Code 0082 selects flash control register
// - Code 0083 selects flash data register
// - Code 0084 selects flash address register
// - Code 0085 selects flash scale register
// - Boundary chain is 87 bits long
// - External test updates; sample never drives
// - External test forces internal inputs high
// - Bits 0,1: reset drive enable and level
// - Bit 2 captures crystal input only
// - Bit 3 weak pullup enable
// - Bits 4-11 register bus address
// - Bits 12-19 register bus data
// - Bits 20-22 write, read, rmw strobes
// - Odd port bits carry output enables
// - Even port bits carry pin levels
// - Identification fields: version, part, maker, one
module jbt_tap #(
  parameter int          NUM_PORT_PINS = 32,     // Four byte-wide ports
  parameter logic [3:0]  ID_VERSION    = 4'h1,   // Arbitrary value
  parameter logic [15:0] ID_PART       = 16'h0001, // Arbitrary value
  parameter logic [10:0] ID_MAKER      = 11'h001 // Arbitrary value
) (
  input  wire logic                REF_CLK,
  input  wire logic                RST_N,
  input  wire logic                TCK,
  input  wire logic                TMS,
  input  wire logic                TDI,
  output logic                     TDO,
  output logic                     TDO_OE,
  input  wire logic                RST_DRV_EN_IN,
  input  wire logic                RST_PIN_IN,
  input  wire logic                XTAL_IN,
  input  wire logic                WEAK_PU_IN,
  input  wire jbt_pkg::jbt_regbus_t REGBUS_CAP,
  input  wire jbt_pkg::jbt_port_t  PORT_CAP,
  output jbt_pkg::jbt_port_t       PORT_DRV,
  output logic                     RST_OE,
  output logic                     RST_OUT,
  output logic                     WEAK_PU_OUT,
  output jbt_pkg::jbt_regbus_t     REGBUS_DRV,
  output logic                     BSCAN_DRIVE,
  output logic [31:0]              CORE_PORT_IN,
  output logic                     CORE_RST_IN,
  input  wire logic                FLASH_BUSY,
  input  wire logic [17:0]         FLASH_RDATA,
  output logic                     FLASH_REQ,
  output jbt_pkg::jbt_fcmd_t       FLASH_CMD
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (`JBT_B_PORT_LO + 2 * NUM_PORT_PINS != `JBT_BSCAN_W) begin : g_bad_pins
    $error("Port pin count does not fill the boundary chain");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  jbt_pkg::jbt_tck_st_t t;         // Test clock state
  jbt_pkg::jbt_tck_st_t next_t;    // Its next value
  jbt_pkg::jbt_ref_st_t r;         // Reference clock state
  jbt_pkg::jbt_ref_st_t next_r;    // Its next value
  logic [86:0]          cap_raw;   // Raw boundary capture sources
  logic [31:0]          id_word;   // Identification constant
  logic                 tdo_q;     // Test data out, falling edge
  logic                 tdo_oe_q;  // Test data out enable

  // Identification word, bit 0 fixed at one
  assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // ----------------------------------------------------------------
  // Boundary capture sources
  // ----------------------------------------------------------------
  assign cap_raw[`JBT_B_RST_OE]  = RST_DRV_EN_IN;
  assign cap_raw[`JBT_B_RST_VAL] = RST_PIN_IN;
  assign cap_raw[`JBT_B_XTAL]    = XTAL_IN;
  assign cap_raw[`JBT_B_WPU]     = WEAK_PU_IN;
  assign cap_raw[`JBT_B_ADDR_LO +: 8] = REGBUS_CAP.addr;
  assign cap_raw[`JBT_B_DATA_LO +: 8] = REGBUS_CAP.data;
  assign cap_raw[`JBT_B_STB_WR]  = REGBUS_CAP.wr;
  assign cap_raw[`JBT_B_STB_RD]  = REGBUS_CAP.rd;
  assign cap_raw[`JBT_B_STB_RMW] = REGBUS_CAP.rmw;

  // Port pins: enable at odd bit, level at the even bit above
  for (genvar i = 0; i < NUM_PORT_PINS; i++) begin : g_cap
    assign cap_raw[`JBT_B_PORT_LO + 2 * i]     = PORT_CAP.oe[i];
    assign cap_raw[`JBT_B_PORT_LO + 2 * i + 1] = PORT_CAP.dat[i];
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Any code outside the eight falls back to bypass
  function automatic jbt_pkg::jbt_sel_t decode(input logic [15:0] code);
    case (code)
      `JBT_I_EXTEST, `JBT_I_SAMPLE: decode = jbt_pkg::SEL_BSCAN;
      `JBT_I_IDCODE:                decode = jbt_pkg::SEL_ID;
      `JBT_I_FCON, `JBT_I_FDAT,
      `JBT_I_FADR, `JBT_I_FSCL:     decode = jbt_pkg::SEL_FLASH;
      default:                      decode = jbt_pkg::SEL_BYP;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Test clock domain: tap controller and data registers
  // ----------------------------------------------------------------
  // Next state of everything on the test clock
  always_comb begin
    next_t         = t;
    next_t.cap_s1  = cap_raw;      // Pins and core signals are async here
    next_t.cap_s2  = t.cap_s1;
    next_t.stat_s1 = {FLASH_RDATA, FLASH_BUSY};
    next_t.stat_s2 = t.stat_s1;
    // Standard tap sequence steered by mode select
    case (t.state)
      jbt_pkg::S_TLR:     next_t.state = TMS ? jbt_pkg::S_TLR     : jbt_pkg::S_RTI;
      jbt_pkg::S_RTI:     next_t.state = TMS ? jbt_pkg::S_SEL_DR  : jbt_pkg::S_RTI;
      jbt_pkg::S_SEL_DR:  next_t.state = TMS ? jbt_pkg::S_SEL_INS : jbt_pkg::S_CAP_DR;
      jbt_pkg::S_CAP_DR:  next_t.state = TMS ? jbt_pkg::S_EX1_DR  : jbt_pkg::S_SH_DR;
      jbt_pkg::S_SH_DR:   next_t.state = TMS ? jbt_pkg::S_EX1_DR  : jbt_pkg::S_SH_DR;
      jbt_pkg::S_EX1_DR:  next_t.state = TMS ? jbt_pkg::S_UPD_DR  : jbt_pkg::S_PA_DR;
      jbt_pkg::S_PA_DR:   next_t.state = TMS ? jbt_pkg::S_EX2_DR  : jbt_pkg::S_PA_DR;
      jbt_pkg::S_EX2_DR:  next_t.state = TMS ? jbt_pkg::S_UPD_DR  : jbt_pkg::S_SH_DR;
      jbt_pkg::S_UPD_DR:  next_t.state = TMS ? jbt_pkg::S_SEL_DR  : jbt_pkg::S_RTI;
      jbt_pkg::S_SEL_INS: next_t.state = TMS ? jbt_pkg::S_TLR     : jbt_pkg::S_CAP_INS;
      jbt_pkg::S_CAP_INS: next_t.state = TMS ? jbt_pkg::S_EX1_INS : jbt_pkg::S_SH_INS;
      jbt_pkg::S_SH_INS:  next_t.state = TMS ? jbt_pkg::S_EX1_INS : jbt_pkg::S_SH_INS;
      jbt_pkg::S_EX1_INS: next_t.state = TMS ? jbt_pkg::S_UPD_INS : jbt_pkg::S_PA_INS;
      jbt_pkg::S_PA_INS:  next_t.state = TMS ? jbt_pkg::S_EX2_INS : jbt_pkg::S_PA_INS;
      jbt_pkg::S_EX2_INS: next_t.state = TMS ? jbt_pkg::S_UPD_INS : jbt_pkg::S_SH_INS;
      jbt_pkg::S_UPD_INS: next_t.state = TMS ? jbt_pkg::S_SEL_DR  : jbt_pkg::S_RTI;
      default:            next_t.state = jbt_pkg::S_TLR;
    endcase
    // Actions of the current state
    case (t.state)
      // Reset parks on identification
      jbt_pkg::S_TLR: begin
        next_t.ins = `JBT_INS_RESET;
      end
      jbt_pkg::S_CAP_INS: begin
        next_t.ins_sh = `JBT_INS_CAPT;
      end
      // Sixteen-bit instruction shift, lsb first
      jbt_pkg::S_SH_INS: begin
        next_t.ins_sh = {TDI, t.ins_sh[15:1]};
      end
      jbt_pkg::S_UPD_INS: begin
        next_t.ins = t.ins_sh;
      end
      // Load the selected register
      jbt_pkg::S_CAP_DR: begin
        case (t.sel)
          jbt_pkg::SEL_BSCAN: next_t.dr_sh = t.cap_s2;
          jbt_pkg::SEL_ID:    next_t.dr_sh = {55'h0, id_word};
          jbt_pkg::SEL_FLASH: next_t.dr_sh = {67'h0, 1'b0, t.stat_s2};
          default:            next_t.dr_sh = 87'h0;
        endcase
      end
      // Shift toward data out; data in enters at the register's top bit
      jbt_pkg::S_SH_DR: begin
        next_t.dr_sh = t.dr_sh >> 1;
        case (t.sel)
          jbt_pkg::SEL_BSCAN: next_t.dr_sh[`JBT_BSCAN_W - 1] = TDI;
          jbt_pkg::SEL_ID:    next_t.dr_sh[`JBT_ID_W - 1]    = TDI;
          jbt_pkg::SEL_FLASH: next_t.dr_sh[`JBT_FLASH_W - 1] = TDI;
          default:            next_t.dr_sh[0]                = TDI;
        endcase
      end
      jbt_pkg::S_UPD_DR: begin
        // Preload fills the update stage; only external test drives it out
        if (t.sel == jbt_pkg::SEL_BSCAN) begin
          next_t.upd = t.dr_sh;
        end
        // Read or write opcode launches when the engine is idle; poll does nothing
        else if (t.sel == jbt_pkg::SEL_FLASH && t.dr_sh[`JBT_F_OP_HI] &&
                 !t.stat_s2[0]) begin
          next_t.fl_cmd.target = t.ins[1:0] - 2'h2;
          next_t.fl_cmd.wr     = t.dr_sh[`JBT_F_OP_LO];
          next_t.fl_cmd.wdata  = t.dr_sh[17:0];
          next_t.fl_tgl        = ~t.fl_tgl;
        end
      end
      default: begin
      end
    endcase
    next_t.sel = decode(next_t.ins);
    next_t.ext = (next_t.ins == `JBT_I_EXTEST);
  end

  // Test clock registers
  always_ff @(posedge TCK or negedge RST_N) begin
    if (!RST_N) begin
      t       <= '0;
      t.ins   <= `JBT_INS_RESET;
      t.sel   <= jbt_pkg::SEL_ID;
      t.state <= jbt_pkg::S_TLR;
    end else begin
      t <= next_t;
    end
  end

  // Data out changes on the falling edge, enabled only while shifting
  always_ff @(negedge TCK or negedge RST_N) begin
    if (!RST_N) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= (t.state == jbt_pkg::S_SH_INS) ? t.ins_sh[0] : t.dr_sh[0];
      tdo_oe_q <= (t.state == jbt_pkg::S_SH_INS) || (t.state == jbt_pkg::S_SH_DR);
    end
  end

  // ----------------------------------------------------------------
  // Reference clock domain: pin drive and core input forcing
  // ----------------------------------------------------------------
  // Update bits cross as levels; they only change in Update-DR and settle
  // long before any pin could care, so a per-bit skew of one edge is fine
  always_comb begin
    next_r        = r;
    next_r.ext_s1 = t.ext;
    next_r.ext_s2 = r.ext_s1;
    next_r.upd_s1 = t.upd;
    next_r.upd_s2 = r.upd_s1;
    next_r.tgl_s1 = t.fl_tgl;
    next_r.tgl_s2 = r.tgl_s1;
    next_r.tgl_s3 = r.tgl_s2;
    next_r.pin_s1 = {RST_PIN_IN, PORT_CAP.dat};
    next_r.pin_s2 = r.pin_s1;
    // Drive only under external test; sample leaves pins alone
    if (r.ext_s2) begin
      next_r.rst_oe   = r.upd_s2[`JBT_B_RST_OE];
      next_r.rst_out  = r.upd_s2[`JBT_B_RST_VAL];
      next_r.wpu      = r.upd_s2[`JBT_B_WPU];
      next_r.bus.addr = r.upd_s2[`JBT_B_ADDR_LO +: 8];
      next_r.bus.data = r.upd_s2[`JBT_B_DATA_LO +: 8];
      next_r.bus.wr   = r.upd_s2[`JBT_B_STB_WR];
      next_r.bus.rd   = r.upd_s2[`JBT_B_STB_RD];
      next_r.bus.rmw  = r.upd_s2[`JBT_B_STB_RMW];
      for (int i = 0; i < 32; i++) begin
        next_r.drv.oe[i]  = r.upd_s2[`JBT_B_PORT_LO + 2 * i];
        next_r.drv.dat[i] = r.upd_s2[`JBT_B_PORT_LO + 2 * i + 1];
      end
      next_r.core_in  = '1;
    end else begin
      next_r.rst_oe   = 1'b0;
      next_r.rst_out  = 1'b0;
      next_r.wpu      = 1'b0;
      next_r.bus      = '0;
      next_r.drv      = '0;
      next_r.core_in  = r.pin_s2;
    end
    // Command word is stable before its toggle arrives
    next_r.fl_req = r.tgl_s2 ^ r.tgl_s3;
    if (r.tgl_s2 ^ r.tgl_s3) begin
      next_r.fl_cmd = t.fl_cmd;
    end
  end

  // Reference clock registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign TDO          = tdo_q;
  assign TDO_OE       = tdo_oe_q;
  assign PORT_DRV     = r.drv;
  assign RST_OE       = r.rst_oe;
  assign RST_OUT      = r.rst_out;
  assign WEAK_PU_OUT  = r.wpu;
  assign REGBUS_DRV   = r.bus;
  assign BSCAN_DRIVE  = r.ext_s2;
  assign CORE_PORT_IN = r.core_in[31:0];
  assign CORE_RST_IN  = r.core_in[32];
  assign FLASH_REQ    = r.fl_req;
  assign FLASH_CMD    = r.fl_cmd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Link side: controller, instruction and data paths
  a_five_ones_reset: assert property (@(posedge TCK) disable iff (!RST_N)
    TMS [*5] |=> t.state == jbt_pkg::S_TLR)
    else $error("Five high mode selects did not reach reset");

  a_ins_update: assert property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_UPD_INS |=> t.ins == $past(t.ins_sh))
    else $error("Instruction not loaded at update");

  a_reset_ins_id: assert property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_TLR |=> t.ins == `JBT_I_IDCODE && t.sel == jbt_pkg::SEL_ID)
    else $error("Test reset did not select identification");

  a_undef_bypass: assert property (@(posedge TCK) disable iff (!RST_N)
    t.ins == 16'h1234 |-> t.sel == jbt_pkg::SEL_BYP)
    else $error("Undefined code did not select bypass");

  a_id_capture: assert property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_CAP_DR && t.sel == jbt_pkg::SEL_ID
    |=> t.dr_sh[31:0] == id_word && t.dr_sh[0])
    else $error("Identification word not captured");

  a_bypass_stage: assert property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_SH_DR && t.sel == jbt_pkg::SEL_BYP |=> tdo_q == $past(TDI))
    else $error("Bypass is not a single stage");

  a_bscan_capture: assert property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_CAP_DR && t.sel == jbt_pkg::SEL_BSCAN
    |=> t.dr_sh == $past(t.cap_s2))
    else $error("Boundary chain did not capture");

  a_flash_poll_quiet: assert property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_UPD_DR && !t.dr_sh[`JBT_F_OP_HI] |=> $stable(t.fl_tgl))
    else $error("Poll launched a flash command");

  // Pin side: outputs follow the chain only under external test
  a_sample_no_drive: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !r.ext_s2 |=> PORT_DRV == '0 && !RST_OE && REGBUS_DRV == '0)
    else $error("Boundary drove pins outside external test");

  a_extest_force: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    r.ext_s2 |=> CORE_PORT_IN == 32'hffffffff && CORE_RST_IN)
    else $error("Inputs not forced high in external test");

  a_extest_map: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    r.ext_s2 |=> PORT_DRV.oe[0] == $past(r.upd_s2[23]) &&
                 PORT_DRV.dat[31] == $past(r.upd_s2[86]) &&
                 RST_OUT == $past(r.upd_s2[1]))
    else $error("Boundary bits mapped to wrong pins");

  a_flash_req_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    FLASH_REQ |=> !FLASH_REQ)
    else $error("Flash request longer than one cycle");

  // Data out drives only while a register shifts; the line is released otherwise
  a_tdo_enable: assert property (@(posedge TCK) disable iff (!RST_N)
    tdo_oe_q == (t.state == jbt_pkg::S_SH_INS || t.state == jbt_pkg::S_SH_DR))
    else $error("Data out enable outside a shift state");

  // Reset drive enable and weak pullup follow their own boundary bits
  a_extest_ctrl: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    r.ext_s2 |=> RST_OE == $past(r.upd_s2[0]) && WEAK_PU_OUT == $past(r.upd_s2[3]))
    else $error("Reset enable or weak pullup not driven from chain");

  c_extest_drive: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    r.ext_s2 && PORT_DRV.oe != '0);
  c_flash_launch: cover property (@(posedge REF_CLK) disable iff (!RST_N) FLASH_REQ);
  c_id_shift: cover property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_SH_DR && t.sel == jbt_pkg::SEL_ID);
  c_ins_load: cover property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_UPD_INS);
  // A command arriving while the engine is busy must be dropped
  c_busy_refused: cover property (@(posedge TCK) disable iff (!RST_N)
    t.state == jbt_pkg::S_UPD_DR && t.sel == jbt_pkg::SEL_FLASH && t.stat_s2[0]);

endmodule // jbt_tap

// [bench/jbt_host.sv]
`timescale 1ns/1ps
// Test controller model; its clock stands still between frames
module jbt_host (
  output logic      TCK,
  output logic      TMS,
  output logic      TDI,
  input  wire logic TDO
);
  // One short pulse while reset is held, then idle low
  initial begin
    {TCK, TMS, TDI} = 3'h2;
    #2.3 TCK = 1'h1;
    #8 TCK = 1'h0;
  end
  // One link clock: set after the fall, sample just before the rise
  task automatic tick(input logic m, input logic di, output logic q);
    #1 TMS = m;
    TDI = di;
    #31 q = TDO;
    TCK = 1'h1;
    #32 TCK = 1'h0;
  endtask
  // Idle to shift, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [86:0] din,
                      output logic [86:0] dout);
    logic q;
    dout = '0;
    tick(1'h1, ~TDI, q);
    if (ir) begin
      tick(1'h1, ~TDI, q);
    end
    tick(1'h0, ~TDI, q);
    tick(1'h0, ~TDI, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'h1, ~TDI, q);
    tick(1'h0, ~TDI, q);
    TDI = ~TDI; // Released line toggles so no stale level is trusted
  endtask
endmodule // jbt_host

// [bench/test_jtag_boundary_scan_tap.sv]
`timescale 1ns/1ps
module test_jtag_boundary_scan_tap;
  logic REF_CLK = 1'h0, RST_N = 1'h0, FLASH_BUSY = 1'h0, q;
  wire  TCK, TMS, TDI, TDO;
  logic RST_DRV_EN_IN, RST_PIN_IN, XTAL_IN, WEAK_PU_IN, RST_OE, RST_OUT;
  logic WEAK_PU_OUT, BSCAN_DRIVE, CORE_RST_IN, FLASH_REQ, TDO_OE;
  wire  tdo_pin = (TDO_OE === 1'h1) ? TDO : ~TDO; // Released pin reads inverted
  logic [17:0] FLASH_RDATA = 18'h2d5a3;
  logic [31:0] CORE_PORT_IN;
  jbt_pkg::jbt_regbus_t REGBUS_CAP, REGBUS_DRV;
  jbt_pkg::jbt_port_t   PORT_CAP, PORT_DRV;
  jbt_pkg::jbt_fcmd_t   FLASH_CMD, fcmd;
  logic [86:0] iv = '0, ov, d; // Pin inputs and outputs in chain order
  logic [7:0]  nreq = 8'h0, n0;
  int fail_count = 0, num_checks = 0, noe = 0; // noe: TCK edges with data out enabled
  localparam logic [86:0] A = 87'h3a5c3e91f06b7d48a3c5e1, B = 87'h15a3c96e0f4b2d87e1935c;
  localparam logic [86:0] C = 87'h2c3a5f0e1d96b84a7c2e1b, M = ~87'h4;
  always #2 REF_CLK = ~REF_CLK;
  // Map chain-order vectors onto the pin ports; bit 2 drives nothing
  always_comb begin
    {RST_DRV_EN_IN, RST_PIN_IN, XTAL_IN, WEAK_PU_IN} = {iv[0], iv[1], iv[2], iv[3]};
    REGBUS_CAP = {iv[11:4], iv[19:12], iv[20], iv[21], iv[22]};
    ov = '0;
    {ov[0], ov[1], ov[3]} = {RST_OE, RST_OUT, WEAK_PU_OUT};
    ov[22:4] = {REGBUS_DRV.rmw, REGBUS_DRV.rd, REGBUS_DRV.wr, REGBUS_DRV.data,
                REGBUS_DRV.addr};
    for (int i = 0; i < 32; i++) begin
      {PORT_CAP.oe[i], PORT_CAP.dat[i]} = {iv[23 + 2 * i], iv[24 + 2 * i]};
      {ov[23 + 2 * i], ov[24 + 2 * i]} = {PORT_DRV.oe[i], PORT_DRV.dat[i]};
    end
  end
  // Count flash launches; a stretched pulse shows up as an extra count
  always @(posedge REF_CLK) begin
    if (FLASH_REQ === 1'h1) begin
      nreq <= nreq + 8'h1;
      fcmd <= FLASH_CMD;
    end
  end
  always @(posedge TCK) begin
    if (TDO_OE === 1'h1) noe++;
  end
  jbt_host host (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(tdo_pin));
  jbt_tap #(.ID_VERSION(4'h5), .ID_PART(16'hc3a1), .ID_MAKER(11'h2b7)) DUT ( // Arbitrary
    .REF_CLK(REF_CLK), .RST_N(RST_N), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
    .TDO_OE(TDO_OE), .RST_DRV_EN_IN(RST_DRV_EN_IN), .RST_PIN_IN(RST_PIN_IN),
    .XTAL_IN(XTAL_IN), .WEAK_PU_IN(WEAK_PU_IN), .REGBUS_CAP(REGBUS_CAP),
    .PORT_CAP(PORT_CAP), .PORT_DRV(PORT_DRV), .RST_OE(RST_OE), .RST_OUT(RST_OUT),
    .WEAK_PU_OUT(WEAK_PU_OUT), .REGBUS_DRV(REGBUS_DRV), .BSCAN_DRIVE(BSCAN_DRIVE),
    .CORE_PORT_IN(CORE_PORT_IN), .CORE_RST_IN(CORE_RST_IN), .FLASH_BUSY(FLASH_BUSY),
    .FLASH_RDATA(FLASH_RDATA), .FLASH_REQ(FLASH_REQ), .FLASH_CMD(FLASH_CMD));
  task automatic chk(input logic [86:0] g, input logic [86:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic drive(input logic [86:0] v, input logic b);
    @(posedge REF_CLK);
    #1 iv = v;
    FLASH_BUSY = b;
  endtask
  // Load an instruction; the shifted-out capture is always 0001
  task automatic ir(input logic [15:0] c);
    int oe0;
    oe0 = noe;
    host.scan(1'h1, 16, {71'h0, c}, d);
    chk(d[15:0], 16'h0001);
    chk(87'(noe - oe0), 87'h10);
  endtask
  task automatic test_done;
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog: the sequence needs about a fifth of this span
  initial begin
    #200000;
    fail_count++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge REF_CLK);
    #1 RST_N = 1'h1;
    host.tick(1'h0, 1'h0, q);
    host.scan(1'h0, 32, '0, d);
    chk(d[31:0], {4'h5, 16'hc3a1, 11'h2b7, 1'h1});
    ir(16'hffff);
    host.scan(1'h0, 2, 87'h1, d);
    chk(d[1:0], 2'h2);
    ir(16'h1234);
    host.scan(1'h0, 2, 87'h1, d);
    chk(d[1:0], 2'h2);
    // Sample observes and preloads but never drives
    drive(A, 1'h0);
    ir(16'h0002);
    host.scan(1'h0, 87, B, d);
    chk(d, A);
    repeat (4) @(posedge REF_CLK);
    chk(ov, '0);
    chk({BSCAN_DRIVE, CORE_PORT_IN, CORE_RST_IN}, {1'h0, PORT_CAP.dat, iv[1]});
    // External test drives the preloaded pattern, then a fresh one
    ir(16'h0000);
    repeat (4) @(posedge REF_CLK);
    chk(ov, B & M);
    chk({BSCAN_DRIVE, CORE_PORT_IN, CORE_RST_IN}, {1'h1, 32'hffffffff, 1'h1});
    drive(C, 1'h0);
    host.scan(1'h0, 87, A, d);
    chk(d, C);
    repeat (4) @(posedge REF_CLK);
    chk(ov, A & M);
    ir(16'h0004);
    repeat (4) @(posedge REF_CLK);
    chk(ov, '0);
    // Each flash register takes a write command
    for (int t = 0; t < 4; t++) begin
      ir(16'h0082 + 16'(t));
      n0 = nreq;
      host.scan(1'h0, 20, {67'h0, 2'h3, 18'h1a5c3 ^ 18'(t)}, d);
      repeat (4) @(posedge REF_CLK);
      chk({nreq - n0, fcmd}, {8'h1, 2'(t), 1'h1, 18'h1a5c3 ^ 18'(t)});
    end
    n0 = nreq;
    host.scan(1'h0, 20, {67'h0, 2'h2, 18'h0}, d);
    repeat (4) @(posedge REF_CLK);
    chk({nreq - n0, fcmd.wr}, {8'h1, 1'h0});
    // Busy refuses a write; a poll never launches anything
    drive(C, 1'h1);
    ir(16'h0083);
    n0 = nreq;
    host.scan(1'h0, 20, {67'h0, 2'h3, 18'h3}, d);
    chk(d[19:0], {1'h0, 18'h2d5a3, 1'h1});
    drive(C, 1'h0);
    host.scan(1'h0, 20, {67'h0, 2'h1, 18'h3}, d);
    repeat (4) @(posedge REF_CLK);
    chk({nreq - n0, d[19:0]}, {8'h0, 1'h0, 18'h2d5a3, 1'h0});
    test_done;
  end
endmodule // test_jtag_boundary_scan_tap
